// ### src/ddrdl_consts.vh
// constants for the ddr3 dll-mode and clock-change command front end
`ifndef DDRDL_CONSTS_VH
`define DDRDL_CONSTS_VH
// ----------------------------------------
// command encodings {ras_n,cas_n,we_n}
// ----------------------------------------
`define DDRDL_CMD_MRS     3'h0
`define DDRDL_CMD_REF     3'h1
`define DDRDL_CMD_PRE     3'h2
`define DDRDL_CMD_ACT     3'h3
`define DDRDL_CMD_WR      3'h4
`define DDRDL_CMD_RD      3'h5
`define DDRDL_CMD_ZQ      3'h6
`define DDRDL_CMD_NOP     3'h7
// ----------------------------------------
// mode register selects and field positions
// ----------------------------------------
`define DDRDL_MR0         3'h0
`define DDRDL_MR1         3'h1
`define DDRDL_MR2         3'h2
`define DDRDL_MR1_DLLOFF  0
`define DDRDL_MR0_DLLRST  8
`define DDRDL_MR1_RTT0    2
`define DDRDL_MR1_RTT1    6
`define DDRDL_MR1_RTT2    9
`define DDRDL_MR0_CL_LO   4
`define DDRDL_MR0_CL_HI   6
`define DDRDL_MR2_CWL_LO  3
`define DDRDL_MR2_CWL_HI  5
// ----------------------------------------
// latency codes and reset values
// ----------------------------------------
`define DDRDL_CL6_CODE    3'h2
`define DDRDL_CWL6_CODE   3'h1
`define DDRDL_CL_RST      4'h6
`define DDRDL_AL_RST      4'h0
`define DDRDL_BURST_LEN   4'h4
// ----------------------------------------
// clock rate and timing
// ----------------------------------------
`define DDRDL_CLK_PERIOD_NS 50
`define DDRDL_TCKSRE_NS     100
`define DDRDL_TCKSRE_CYC    ((`DDRDL_TCKSRE_NS + `DDRDL_CLK_PERIOD_NS - 1) / `DDRDL_CLK_PERIOD_NS)
`endif

// ### src/ddrdl_mode_regs.v
// small mode-register memory with a registered read port
module ddrdl_mode_regs #(
	parameter DEPTH = 4,
	parameter AW    = 2,
	parameter DW    = 14
) (
	// clock and reset
	input  wire          mclk,
	input  wire          rst_n,
	// write port
	input  wire          wr_en,
	input  wire [AW-1:0] wr_addr,
	input  wire [DW-1:0] wr_data,
	// read port
	input  wire [AW-1:0] rd_addr,
	output reg  [DW-1:0] rd_data
);
	reg [DW-1:0] mem [0:DEPTH-1];  // one word per mode register
	genvar g;

	// ----------------------------------------
	// storage, all words cleared at reset
	// ----------------------------------------
	generate
		for (g = 0; g < DEPTH; g = g + 1) begin : g_word
			always @(posedge mclk) begin
				if (!rst_n) begin
					mem[g] <= {DW{1'b0}};
				end else if (wr_en && wr_addr == g) begin
					mem[g] <= wr_data;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// registered read
	// ----------------------------------------
	always @(posedge mclk) begin
		if (!rst_n) begin
			rd_data <= {DW{1'b0}};
		end else begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule // ddrdl_mode_regs

// ### src/ddrdl_core.v
// ddr3 command front end: nop/deselect, dll-off mode, read timing, clock-change guard
// Notes on behaviour
// [RQ1] nop starts nothing, running burst continues
// [RQ2] chip select high ignores all command inputs
// [RQ3] mr1 a0 set enters dll-off, clear leaves
// [RQ4] dll-off supports cl six with cwl six
// [RQ5] dll-off read reference at al+cl-1 cycles
// [RQ6] controller keeps dll-off clock below maximum
// [RQ7] controller idles, precharges, termination off first
// [RQ8] controller: mr1 write, tmod, self-refresh, tcksre
// [RQ9] controller gives stable clock tcksrx before exit
// [RQ10] cke high, odt low until tmod done
// [RQ11] after exit wait txs, rewrite mode registers
// [RQ12] dll on: a0 low, then dll reset
// [RQ13] cke high, odt low until tdllk done
// [RQ14] controller withholds dll commands until tdllk
// [RQ15] clock changes only in self-refresh or powerdown
// [RQ16] after tcksre in self-refresh clock ignored
// [RQ17] powerdown change: tcksre after cke low
// [RQ18] nominal termination forced off during powerdown
// [RQ19] controller: tcksrx, txp, dll reset, relock
// [RQ20] only nop/deselect during txs after exit
// [RQ21] controller counts each wait in cycles
`include "ddrdl_consts.vh"
module ddrdl_core #(
	parameter CNT_W = 8
) (
	// clock and reset
	input  wire        mclk,
	input  wire        rst_n,
	// command pins, from pads
	input  wire        cke_pin,
	input  wire        cs_n_pin,
	input  wire        ras_n_pin,
	input  wire        cas_n_pin,
	input  wire        we_n_pin,
	input  wire [2:0]  ba_pin,
	input  wire [13:0] addr_pin,
	input  wire        odt_pin,
	// status
	output reg         dll_off,
	output reg         lat_ok,
	output reg         self_refresh,
	output reg         power_down,
	output reg         clk_dont_care,
	output reg         burst_busy,
	output reg         read_ref,
	output reg         rtt_on,
	output reg  [2:0]  mr1_rtt
);
	// ----------------------------------------
	// pin synchronisers, two stages
	// ----------------------------------------
	localparam PW = 23;  // 1+1+3+3+14+1 pin bits, no spare
	reg  [PW-1:0] sync1;   // first stage, read only by sync2
	reg  [PW-1:0] sync2;   // safe to decode
	reg           cke_prev;
	always @(posedge mclk) begin
		if (!rst_n) begin
			sync1 <= {PW{1'b1}};
			sync2 <= {PW{1'b1}};
		end else begin
			sync1 <= {cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, ba_pin, addr_pin, odt_pin};
			sync2 <= sync1;
		end
	end
	// field split must mirror the packing order of sync1 exactly
	wire        cke  = sync2[22];
	wire        cs_n = sync2[21];
	wire [2:0]  cmd  = sync2[20:18];
	wire [2:0]  ba   = sync2[17:15];
	wire [13:0] addr = sync2[14:1];
	wire        odt  = sync2[0];

	// ----------------------------------------
	// command decode: only with cke held high
	// ----------------------------------------
	function is_cmd;
		input [2:0] c;
		input [2:0] want;
		begin
			// deselect masks every other input [RQ2]
			is_cmd = (cs_n == 1'b0) && cke && cke_prev && (c == want);
		end
	endfunction
	wire do_mrs = is_cmd(cmd, `DDRDL_CMD_MRS);
	wire do_rd  = is_cmd(cmd, `DDRDL_CMD_RD);
	wire do_wr  = is_cmd(cmd, `DDRDL_CMD_WR);
	wire do_ref = is_cmd(cmd, `DDRDL_CMD_REF);
	// cke falling with nop/deselect or refresh picks powerdown or self-refresh
	wire sre_go = (cs_n == 1'b0) && cke_prev && !cke && cmd == `DDRDL_CMD_REF;
	wire pde_go = cke_prev && !cke && !sre_go && !burst_busy;
	wire exit_go = !cke_prev && cke;

	// ----------------------------------------
	// mode register store
	// ----------------------------------------
	wire [13:0] mr_rd;
	reg  [1:0]  rd_sel;
	ddrdl_mode_regs #(.DEPTH(4), .AW(2), .DW(14)) u_mr (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.wr_en   (do_mrs),
		.wr_addr (ba[1:0]),
		.wr_data (addr),
		.rd_addr (rd_sel),
		.rd_data (mr_rd)
	);
	// walk the three used registers so latency checks see them
	reg [13:0] mr0_q;
	reg [13:0] mr2_q;
	always @(posedge mclk) begin
		if (!rst_n) begin
			rd_sel <= 2'h0;
			mr0_q  <= 14'h0000;
			mr2_q  <= 14'h0000;
		end else begin
			rd_sel <= (rd_sel == 2'h2) ? 2'h0 : rd_sel + 2'h1;
			// read data lags the select by one cycle
			if (rd_sel == 2'h1) mr0_q <= mr_rd;
			if (rd_sel == 2'h0) mr2_q <= mr_rd;
		end
	end

	// ----------------------------------------
	// dll-off flag tracks mr1 bit 0
	// ----------------------------------------
	always @(posedge mclk) begin
		if (!rst_n) begin
			dll_off <= 1'b0;
			mr1_rtt <= 3'h0;
		end else if (do_mrs && ba == `DDRDL_MR1) begin
			dll_off <= addr[`DDRDL_MR1_DLLOFF];  // [RQ3]
			mr1_rtt <= {addr[`DDRDL_MR1_RTT2], addr[`DDRDL_MR1_RTT1], addr[`DDRDL_MR1_RTT0]};
		end
	end

	// ----------------------------------------
	// latency check: dll-off wants cl6/cwl6
	// ----------------------------------------
	always @(posedge mclk) begin
		if (!rst_n) begin
			lat_ok <= 1'b1;
		end else begin
			// with dll on any setting is acceptable here
			lat_ok <= !dll_off ||
				(mr0_q[`DDRDL_MR0_CL_HI:`DDRDL_MR0_CL_LO] == `DDRDL_CL6_CODE &&
				 mr2_q[`DDRDL_MR2_CWL_HI:`DDRDL_MR2_CWL_LO] == `DDRDL_CWL6_CODE);  // [RQ4]
		end
	end

	// ----------------------------------------
	// read latency counter and burst tracking
	// ----------------------------------------
	reg [CNT_W-1:0] rd_cnt;     // cycles until the read reference edge
	reg             rd_pend;
	reg [3:0]       burst_cnt;  // remaining burst clocks
	wire [CNT_W-1:0] lat_full = {{(CNT_W-4){1'b0}}, `DDRDL_AL_RST + `DDRDL_CL_RST};
	always @(posedge mclk) begin
		if (!rst_n) begin
			rd_cnt     <= {CNT_W{1'b0}};
			rd_pend    <= 1'b0;
			read_ref   <= 1'b0;
			burst_cnt  <= 4'h0;
			burst_busy <= 1'b0;
		end else begin
			read_ref <= 1'b0;
			if (do_rd && !burst_busy) begin
				// one edge earlier with the dll off [RQ5]
				rd_cnt  <= dll_off ? lat_full - {{(CNT_W-1){1'b0}}, 1'b1} : lat_full;
				rd_pend <= 1'b1;
			end else if (rd_pend) begin
				if (rd_cnt <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
					rd_pend  <= 1'b0;
					read_ref <= 1'b1;
				end
				rd_cnt <= rd_cnt - {{(CNT_W-1){1'b0}}, 1'b1};
			end
			// nop and deselect leave a running burst untouched [RQ1]
			if ((do_rd || do_wr) && !burst_busy) begin
				burst_cnt  <= `DDRDL_BURST_LEN;
				burst_busy <= 1'b1;
			end else if (burst_busy) begin
				burst_cnt  <= burst_cnt - 4'h1;
				burst_busy <= burst_cnt != 4'h1;
			end
		end
	end

	// ----------------------------------------
	// self-refresh and powerdown states
	// ----------------------------------------
	localparam ST_ACTIVE = 2'h0;
	localparam ST_SREF   = 2'h1;
	localparam ST_PDOWN  = 2'h2;
	reg [1:0]       state;
	reg [1:0]       next_state;
	reg [CNT_W-1:0] sre_cnt;    // cycles since clock-stop entry
	always @* begin
		next_state = state;
		case (state)
			ST_ACTIVE: begin
				if (sre_go) next_state = ST_SREF;
				else if (pde_go) next_state = ST_PDOWN;
			end
			ST_SREF:  if (exit_go) next_state = ST_ACTIVE;
			ST_PDOWN: if (exit_go) next_state = ST_ACTIVE;
			default:  next_state = ST_ACTIVE;
		endcase
	end
	always @(posedge mclk) begin
		if (!rst_n) begin
			state         <= ST_ACTIVE;
			cke_prev      <= 1'b1;
			sre_cnt       <= {CNT_W{1'b0}};
			self_refresh  <= 1'b0;
			power_down    <= 1'b0;
			clk_dont_care <= 1'b0;
			rtt_on        <= 1'b0;
		end else begin
			cke_prev     <= cke;
			state        <= next_state;
			self_refresh <= next_state == ST_SREF;
			power_down   <= next_state == ST_PDOWN;
			if (next_state == ST_ACTIVE) begin
				sre_cnt <= {CNT_W{1'b0}};
			end else if (sre_cnt != {CNT_W{1'b1}}) begin
				sre_cnt <= sre_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
			end
			// clock is don't-care once tcksre has run [RQ16]
			clk_dont_care <= next_state != ST_ACTIVE && sre_cnt >= `DDRDL_TCKSRE_CYC - 1;
			// termination off in self-refresh and powerdown [RQ18]
			rtt_on <= next_state == ST_ACTIVE && odt && mr1_rtt != 3'h0 && !do_ref;
		end
	end
endmodule // ddrdl_core

// ### sim/ddrdl_checker.sv
// assertion checker for the ddr3 command front end
`include "ddrdl_consts.vh"
module ddrdl_checker (
	// clock and reset
	input wire        mclk,
	input wire        rst_n,
	// command pins
	input wire        cke_pin,
	input wire        cs_n_pin,
	input wire        ras_n_pin,
	input wire        cas_n_pin,
	input wire        we_n_pin,
	input wire [2:0]  ba_pin,
	input wire [13:0] addr_pin,
	// status
	input wire        dll_off,
	input wire        lat_ok,
	input wire        self_refresh,
	input wire        power_down,
	input wire        clk_dont_care,
	input wire        burst_busy,
	input wire        read_ref,
	input wire        rtt_on,
	input wire [2:0]  mr1_rtt
);
	timeunit 1ns;
	timeprecision 1ps;
	wire [2:0] cmd    = {ras_n_pin, cas_n_pin, we_n_pin};                   // raw code
	wire       taken  = !cs_n_pin && cke_pin;                               // selected
	wire       mr1_wr = taken && cmd == `DDRDL_CMD_MRS && ba_pin == `DDRDL_MR1;
	wire       rw_cmd = taken && (cmd == `DDRDL_CMD_RD || cmd == `DDRDL_CMD_WR);
	wire [2:0] rtt_in = {addr_pin[9], addr_pin[6], addr_pin[2]};              // rtt field
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// pins reach decode two edges later, through the synchronisers
	sequence s_rw;
		rw_cmd && $past(cke_pin) ##2 !burst_busy;
	endsequence
	sequence s_rd_off;
		rw_cmd && cmd == `DDRDL_CMD_RD && $past(cke_pin) ##2 (!burst_busy && dll_off);
	endsequence
	AST_DLL_FOLLOW: assert property (mr1_wr && $past(cke_pin) |-> ##3 dll_off == $past(addr_pin[0], 3))
		else $error("dll_off does not follow a0");
	AST_DLL_CAUSE: assert property ($changed(dll_off) |-> $past(mr1_wr, 3))
		else $error("dll_off moved without a write");
	AST_RTT_FIELD: assert property (mr1_wr && $past(cke_pin) |-> ##3 mr1_rtt == $past(rtt_in, 3))
		else $error("mr1_rtt wrong");
	AST_RD_OFF: assert property (s_rd_off |-> ##5 !read_ref ##1 read_ref)
		else $error("read_ref not at al+cl-1");
	AST_BURST: assert property (s_rw |-> ##1 burst_busy [*4] ##1 !burst_busy)
		else $error("burst length wrong");
	AST_NOP_IDLE: assert property (taken && cmd == `DDRDL_CMD_NOP ##2 !burst_busy |-> ##1 !burst_busy)
		else $error("nop started a burst");
	AST_LAT: assert property (!dll_off [*6] |-> lat_ok)
		else $error("lat_ok low with dll on");
	AST_DONT_CARE: assert property (clk_dont_care |-> self_refresh || power_down)
		else $error("clock ignored while active");
	AST_PD_RTT: assert property (power_down |-> !rtt_on)
		else $error("termination on in power-down");
endmodule // ddrdl_checker

bind ddrdl_core ddrdl_checker i_chk (
	.mclk(mclk), .rst_n(rst_n), .cke_pin(cke_pin), .cs_n_pin(cs_n_pin), .ras_n_pin(ras_n_pin),
	.cas_n_pin(cas_n_pin), .we_n_pin(we_n_pin), .ba_pin(ba_pin), .addr_pin(addr_pin),
	.dll_off(dll_off), .lat_ok(lat_ok), .self_refresh(self_refresh), .power_down(power_down),
	.clk_dont_care(clk_dont_care), .burst_busy(burst_busy), .read_ref(read_ref), .rtt_on(rtt_on),
	.mr1_rtt(mr1_rtt)
);

// ### sim/ddrdl_ctrl_model.sv
// controller-side model driving command, clock-enable and termination pins
`include "ddrdl_consts.vh"
module ddrdl_ctrl_model (
	// clock
	input wire          mclk,
	// pins toward the device
	output logic        cke_pin,
	output logic        cs_n_pin,
	output logic        ras_n_pin,
	output logic        cas_n_pin,
	output logic        we_n_pin,
	output logic [2:0]  ba_pin,
	output logic [13:0] addr_pin,
	output logic        odt_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle, deselected, all banks closed; clock never changes rate
	initial begin
		{cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, odt_pin} = 6'h3e;
		ba_pin = 3'h0;
		addr_pin = 14'h0000;
	end
	// one command at the next edge; calls chain back to back
	task issue(input logic cs, input logic [2:0] c, input logic [2:0] b, input logic [13:0] a);
		@(posedge mclk);
		cs_n_pin <= cs;
		{ras_n_pin, cas_n_pin, we_n_pin} <= c;
		ba_pin <= b;
		addr_pin <= a;
	endtask
	// waits counted in cycles; unowned lines toggle so stale values never look valid
	task idle(input int n);
		repeat (n) begin
			@(posedge mclk);
			cs_n_pin <= 1'b1;
			{ras_n_pin, cas_n_pin, we_n_pin} <= ~{ras_n_pin, cas_n_pin, we_n_pin};
			ba_pin <= ~ba_pin;
			addr_pin <= ~addr_pin;
		end
	endtask
	// cke step; self-refresh entry rides a refresh, termination held off
	task set_cke(input logic v, input logic sr);
		@(posedge mclk);
		cke_pin <= v;
		odt_pin <= 1'b0;
		cs_n_pin <= !sr;
		{ras_n_pin, cas_n_pin, we_n_pin} <= sr ? `DDRDL_CMD_REF : `DDRDL_CMD_NOP;
	endtask
	task set_odt(input logic v);
		@(posedge mclk);
		odt_pin <= v;
	endtask
endmodule // ddrdl_ctrl_model

// ### sim/ddrdl_core_tb.sv
// self-checking bench for the ddr3 command front end
`include "ddrdl_consts.vh"
module ddrdl_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic cs; logic [13:0] a; logic dll; logic [2:0] rtt;} ddrdl_row;
	typedef struct packed {logic cs; logic [2:0] cmd; logic [2:0] ba; logic [13:0] a;} ddrdl_cmd;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	wire         cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, odt_pin;
	wire [2:0]   ba_pin, mr1_rtt;
	wire [13:0]  addr_pin;
	wire         dll_off, lat_ok, self_refresh, power_down, clk_dont_care, burst_busy, read_ref, rtt_on;
	int          err_total = 0;
	int          check_count = 0;
	int          n, first, hits;
	// mr1 writes: select, address, dll_off and rtt expected
	ddrdl_row    rows [4] = '{'{1'b0, 14'h0001, 1'b1, 3'h0}, '{1'b1, 14'h0000, 1'b1, 3'h0},
		'{1'b0, 14'h0244, 1'b0, 3'h7}, '{1'b0, 14'h0005, 1'b1, 3'h1}};
	// scripted commands: select, code, bank, address
	ddrdl_cmd    cmds [8] = '{'{1'b0, `DDRDL_CMD_RD, 3'h0, 14'h0000}, '{1'b0, `DDRDL_CMD_NOP, 3'h0, 14'h0000},
		'{1'b0, `DDRDL_CMD_MRS, `DDRDL_MR0, 14'h0000}, '{1'b0, `DDRDL_CMD_MRS, `DDRDL_MR0, 14'h0020},
		'{1'b0, `DDRDL_CMD_MRS, `DDRDL_MR2, 14'h0008}, '{1'b0, `DDRDL_CMD_MRS, `DDRDL_MR1, 14'h0004},
		'{1'b0, `DDRDL_CMD_MRS, `DDRDL_MR1, 14'h0001}, '{1'b0, `DDRDL_CMD_MRS, `DDRDL_MR0, 14'h0120}};
	always #25 mclk = ~mclk;
	ddrdl_ctrl_model i_ctrl (.mclk(mclk), .cke_pin(cke_pin), .cs_n_pin(cs_n_pin), .ras_n_pin(ras_n_pin),
		.cas_n_pin(cas_n_pin), .we_n_pin(we_n_pin), .ba_pin(ba_pin), .addr_pin(addr_pin), .odt_pin(odt_pin));
	ddrdl_core i_dut (.mclk(mclk), .rst_n(rst_n), .cke_pin(cke_pin), .cs_n_pin(cs_n_pin), .ras_n_pin(ras_n_pin),
		.cas_n_pin(cas_n_pin), .we_n_pin(we_n_pin), .ba_pin(ba_pin), .addr_pin(addr_pin), .odt_pin(odt_pin),
		.dll_off(dll_off), .lat_ok(lat_ok), .self_refresh(self_refresh), .power_down(power_down),
		.clk_dont_care(clk_dont_care), .burst_busy(burst_busy), .read_ref(read_ref), .rtt_on(rtt_on),
		.mr1_rtt(mr1_rtt));
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// drives one row of the command table at the next edge
	task send(input int i);
		i_ctrl.issue(cmds[i].cs, cmds[i].cmd, cmds[i].ba, cmds[i].a);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// two reads back to back: the second lands inside the burst and must vanish
	task rd_pair(input int lat);
		send(0);
		send(0);
		first = 0;
		hits = 0;
		for (n = 1; n <= 16; n++) begin
			i_ctrl.idle(1);
			#1;
			if (read_ref === 1'b1 && first == 0) first = n;
			if (read_ref === 1'b1) hits++;
		end
		chk("read_ref delay", 8'(lat), 8'(first));
		chk("read_ref pulses", 8'h01, 8'(hits));
	endtask
	// whole run is about 180 cycles; sixteen times that means a hang
	initial begin
		repeat (3000) @(posedge mclk);
		err_total++;
		print_verdict;
	end
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		i_ctrl.idle(3);
		#1;
		chk("dll_off", 8'h00, dll_off);
		chk("lat_ok", 8'h01, lat_ok);
		chk("burst_busy", 8'h00, burst_busy);
		$display("test reset done");
		foreach (rows[i]) begin
			i_ctrl.issue(rows[i].cs, `DDRDL_CMD_MRS, `DDRDL_MR1, rows[i].a);
			i_ctrl.idle(5);
			#1;
			chk("dll_off", rows[i].dll, dll_off);
			chk("mr1_rtt", rows[i].rtt, mr1_rtt);
		end
		$display("test mode table done");
		send(2);
		i_ctrl.idle(8);
		#1;
		chk("lat_ok", 8'h00, lat_ok);
		send(3);
		send(4);
		i_ctrl.idle(8);
		#1;
		chk("lat_ok", 8'h01, lat_ok);
		rd_pair(7);
		send(5);
		i_ctrl.idle(5);
		rd_pair(8);
		send(1);
		send(1);
		i_ctrl.idle(3);
		#1;
		chk("burst_busy", 8'h00, burst_busy);
		$display("test reads done");
		i_ctrl.set_odt(1'b1);
		i_ctrl.idle(4);
		#1;
		chk("rtt_on", 8'h01, rtt_on);
		i_ctrl.set_cke(1'b0, 1'b0);
		i_ctrl.idle(6);
		#1;
		chk("power_down", 8'h01, power_down);
		chk("clk_dont_care", 8'h01, clk_dont_care);
		i_ctrl.set_cke(1'b1, 1'b0);
		i_ctrl.idle(6);
		#1;
		chk("power_down", 8'h00, power_down);
		$display("test power-down done");
		send(6);
		i_ctrl.idle(6);
		i_ctrl.set_cke(1'b0, 1'b1);
		i_ctrl.idle(6);
		#1;
		chk("self_refresh", 8'h01, self_refresh);
		chk("clk_dont_care", 8'h01, clk_dont_care);
		chk("dll_off", 8'h01, dll_off);
		i_ctrl.set_cke(1'b1, 1'b0);
		i_ctrl.idle(8);
		#1;
		chk("self_refresh", 8'h00, self_refresh);
		chk("clk_dont_care", 8'h00, clk_dont_care);
		$display("test self-refresh done");
		send(5);
		i_ctrl.idle(4);
		send(7);
		i_ctrl.idle(4);
		send(4);
		i_ctrl.idle(8);
		#1;
		chk("dll_off", 8'h00, dll_off);
		chk("lat_ok", 8'h01, lat_ok);
		rd_pair(8);
		$display("test dll switch done");
		print_verdict;
	end
endmodule // ddrdl_core_tb
